// ==== rtl/usart_pkg.sv ====
// package: constants, register map and carrier types of the serial port control block
// assumes: one clock domain, APB word access, byte address is four times a register index
// What this block does
// [R01] flush aborts operation and empties data buffers
// [R02] software waits one bit after flush
// [R03] two interrupt flags, receive and transmit done
// [R04] interrupt requests gated by their enables
// [R05] two DMA triggers pulsed by done events
// [R06] data buffer reachable as DMA source/destination
// [R07] no DMA while clock phase select is one; the block does not gate the triggers by it, so this is left to the caller
// [R08] status bit 7 picks SPI or UART
// [R09] status bit 6 turns receiver on
// [R10] status bit 5 picks SPI master or slave
// [R11] bit 4 framing fault, set by hardware
// [R12] receive done on first good stop bit
// [R13] bit 3 parity fault, software clears by zero
// [R14] bit 2 received byte ready
// [R15] bit 1 last byte fully transmitted
// [R16] bit 0 read-only busy status
// [R17] seven port registers exist
// [R18] flush at async bit 7 reads zero
// [R19] SPI slave: transmit done at start
// [R20] hardware set beats software clear
package usart_pkg;
  // ---------------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_CTRL_STATUS = 8'h86;
  localparam logic [7:0]  IDX_ASYNC_CTRL  = 8'hC4;
  localparam logic [7:0]  IDX_GENERIC     = 8'hC5;
  localparam logic [7:0]  IDX_DATA_BUF    = 8'hC1;
  localparam logic [7:0]  IDX_RATE        = 8'hC2;
  localparam logic [7:0]  IDX_IRQ_FLAGS   = 8'hC6;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'hC7;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_MODE    = 7;
  localparam int BIT_RXON    = 6;
  localparam int BIT_SLAVE   = 5;
  localparam int BIT_FRAME   = 4;
  localparam int BIT_PARITY  = 3;
  localparam int BIT_RXBYTE  = 2;
  localparam int BIT_TXBYTE  = 1;
  localparam int BIT_ACTIVE  = 0;
  localparam int BIT_FLUSH   = 7;
  localparam int BIT_PHASE   = 6;
  localparam int BIT_RXFLAG  = 0;
  localparam int BIT_TXFLAG  = 1;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0]  RST_ASYNC_CTRL  = 8'h02;
  localparam logic [7:0]  RST_GENERIC     = 8'h00;
  localparam logic [7:0]  RST_RATE        = 8'h00;

  // events from the serial engine, one-cycle pulses on pclk except busy and rx_byte
  typedef struct packed {
    logic       rx_done;      // byte received, first stop bit good
    logic       tx_done;      // last written byte fully shifted out
    logic       slave_start;  // spi slave selected, operation starts
    logic       frame_fault;  // wrong stop bit level
    logic       parity_fault; // parity check failed
    logic       busy;         // level: engine transmitting or receiving
    logic [7:0] rx_byte;      // byte captured with rx_done
  } engine_ev_t;

  // control toward the serial engine
  typedef struct packed {
    logic       uart_mode;    // 1 uart, 0 spi
    logic       receiver_on;
    logic       spi_slave;
    logic [6:0] async_cfg;    // async control bits 6..0
    logic [7:0] generic_cfg;
    logic [7:0] rate_cfg;
    logic [7:0] tx_byte;
    logic       tx_load;      // pulse: new byte written
    logic       flush;        // pulse: abort and empty buffers
  } engine_ctl_t;
endpackage

// ==== rtl/usart_status_flush_events.sv ====
// file: status, flush, interrupt flag and DMA trigger logic of one serial port
// assumes: APB master on pclk, serial engine on the same clock delivering usart_pkg::engine_ev_t
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module usart_status_flush_events (
  input  wire logic                    pclk,        // 25 MHz system clock
  input  wire logic                    presetn,     // async reset, active low
  input  wire logic                    psel,        // apb select
  input  wire logic                    penable,     // apb access phase
  input  wire logic                    pwrite,      // apb direction
  input  wire logic [11:0]             paddr,       // apb byte address
  input  wire logic [31:0]             pwdata,      // apb write data
  output logic      [31:0]             prdata,      // apb read data
  output logic                         pready,      // apb ready
  output logic                         pslverr,     // unmapped address
  input  wire usart_pkg::engine_ev_t   ev,          // engine events
  output usart_pkg::engine_ctl_t       ctl,         // engine controls
  output logic                         rx_irq,      // receive done request
  output logic                         tx_irq,      // transmit done request
  output logic                         rx_dma_trig, // receive dma trigger
  output logic                         tx_dma_trig  // transmit dma trigger
);
  import usart_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  csr;
    logic [6:0]  ucr;
    logic [7:0]  gcr;
    logic [7:0]  baud;
    logic [7:0]  rx_buf;
    logic [7:0]  tx_buf;
    logic        tx_load;
    logic        flush;
    logic        rx_flag;
    logic        tx_flag;
    logic        rx_en;
    logic        tx_en;
    logic        rx_irq;
    logic        tx_irq;
    logic        rx_trig;
    logic        tx_trig;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic       setup;
  logic       wr_acc;
  logic [7:0] idx;
  logic       hit;
  logic       tx_ev;
  logic [7:0] wb;

  assign setup  = psel & ~penable;
  // an unmapped address, aliases included, must never reach a register
  assign wr_acc = psel & penable & s_q.ready & pwrite & hit;
  assign idx    = paddr[9:2];
  assign wb     = pwdata[7:0];
  // unused high address bits must be zero for a hit
  assign hit    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  (idx == IDX_CTRL_STATUS || idx == IDX_ASYNC_CTRL || idx == IDX_GENERIC ||
                   idx == IDX_DATA_BUF || idx == IDX_RATE || idx == IDX_IRQ_FLAGS ||
                   idx == IDX_IRQ_ENABLE); // R17
  // spi slave reports transmit done at the start of the operation
  assign tx_ev  = (!s_q.csr[BIT_MODE] && s_q.csr[BIT_SLAVE]) ? ev.slave_start : ev.tx_done; // R19

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.tx_load = 1'b0;
    s_d.flush   = 1'b0;
    // zero wait state: ready rises in the access phase
    s_d.ready   = setup;
    s_d.err     = setup & ~hit;
    // unmapped reads return zero, even where the index aliases a register
    if (setup && !hit) begin
      s_d.rdata = 32'h00000000;
    end else if (setup) begin
      unique case (idx)
        IDX_CTRL_STATUS: s_d.rdata = {24'h000000, s_q.csr};
        IDX_ASYNC_CTRL:  s_d.rdata = {24'h000000, 1'b0, s_q.ucr}; // R18
        IDX_GENERIC:     s_d.rdata = {24'h000000, s_q.gcr};
        IDX_DATA_BUF:    s_d.rdata = {24'h000000, s_q.rx_buf}; // R06
        IDX_RATE:        s_d.rdata = {24'h000000, s_q.baud};
        IDX_IRQ_FLAGS:   s_d.rdata = {30'h0000000, s_q.tx_flag, s_q.rx_flag};
        IDX_IRQ_ENABLE:  s_d.rdata = {30'h0000000, s_q.tx_en, s_q.rx_en};
        default:         s_d.rdata = 32'h00000000;
      endcase
    end
    // software writes; status bits clear only by zero
    if (wr_acc) begin
      unique case (idx)
        IDX_CTRL_STATUS: begin
          s_d.csr[BIT_MODE]   = wb[BIT_MODE];   // R08
          s_d.csr[BIT_RXON]   = wb[BIT_RXON];   // R09
          s_d.csr[BIT_SLAVE]  = wb[BIT_SLAVE];  // R10
          s_d.csr[BIT_FRAME]  = s_q.csr[BIT_FRAME] & wb[BIT_FRAME];   // R11
          s_d.csr[BIT_PARITY] = s_q.csr[BIT_PARITY] & wb[BIT_PARITY]; // R13
          s_d.csr[BIT_RXBYTE] = s_q.csr[BIT_RXBYTE] & wb[BIT_RXBYTE]; // R14
          s_d.csr[BIT_TXBYTE] = s_q.csr[BIT_TXBYTE] & wb[BIT_TXBYTE]; // R15
        end
        IDX_ASYNC_CTRL: begin
          s_d.ucr   = wb[6:0];
          s_d.flush = wb[BIT_FLUSH]; // R18
        end
        IDX_GENERIC:    s_d.gcr = wb;
        IDX_DATA_BUF: begin
          s_d.tx_buf  = wb; // R06
          s_d.tx_load = 1'b1;
        end
        IDX_RATE:       s_d.baud = wb;
        IDX_IRQ_FLAGS: begin
          s_d.rx_flag = s_q.rx_flag & wb[BIT_RXFLAG];
          s_d.tx_flag = s_q.tx_flag & wb[BIT_TXFLAG];
        end
        IDX_IRQ_ENABLE: begin
          s_d.rx_en = wb[BIT_RXFLAG];
          s_d.tx_en = wb[BIT_TXFLAG];
        end
        default: ;
      endcase
    end
    // hardware sets come after the software clear, so a coincident event survives
    if (ev.frame_fault)  s_d.csr[BIT_FRAME]  = 1'b1; // R11 R20
    if (ev.parity_fault) s_d.csr[BIT_PARITY] = 1'b1; // R13 R20
    if (ev.rx_done) begin
      s_d.csr[BIT_RXBYTE] = 1'b1; // R12 R14 R20
      s_d.rx_buf          = ev.rx_byte;
      s_d.rx_flag         = 1'b1; // R03 R20
    end
    if (ev.tx_done) s_d.csr[BIT_TXBYTE] = 1'b1; // R15 R20
    if (tx_ev)      s_d.tx_flag = 1'b1; // R03 R20
    // busy mirrors the engine and cannot be written
    s_d.csr[BIT_ACTIVE] = ev.busy; // R16
    // flush empties both data buffers; the engine drops its shift state on the pulse
    if (s_q.flush) begin
      s_d.rx_buf = 8'h00; // R01
      s_d.tx_buf = 8'h00; // R01
    end
    // dma triggers share the interrupt events; caller must not use them with phase one
    s_d.rx_trig = ev.rx_done; // R05
    s_d.tx_trig = tx_ev;      // R05
    s_d.rx_irq  = s_d.rx_flag & s_d.rx_en; // R04
    s_d.tx_irq  = s_d.tx_flag & s_d.tx_en; // R04
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.csr  <= RST_CTRL_STATUS;
      s_q.ucr  <= RST_ASYNC_CTRL[6:0];
      s_q.gcr  <= RST_GENERIC;
      s_q.baud <= RST_RATE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign prdata              = s_q.rdata;
  assign pready              = s_q.ready;
  assign pslverr             = s_q.err;
  assign rx_irq              = s_q.rx_irq;
  assign tx_irq              = s_q.tx_irq;
  assign rx_dma_trig         = s_q.rx_trig;
  assign tx_dma_trig         = s_q.tx_trig;
  assign ctl.uart_mode       = s_q.csr[BIT_MODE];
  assign ctl.receiver_on     = s_q.csr[BIT_RXON];
  assign ctl.spi_slave       = s_q.csr[BIT_SLAVE];
  assign ctl.async_cfg       = s_q.ucr;
  assign ctl.generic_cfg     = s_q.gcr;
  assign ctl.rate_cfg        = s_q.baud;
  assign ctl.tx_byte         = s_q.tx_buf;
  assign ctl.tx_load         = s_q.tx_load;
  assign ctl.flush           = s_q.flush;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_q;
  logic [7:0] idx_q;
  logic [7:0] wb_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= 1'b0;
      idx_q <= 8'h00;
      wb_q  <= 8'h00;
    end else begin
      wr_q  <= wr_acc;
      idx_q <= idx;
      wb_q  <= wb;
    end
  end

  a_flush_empties: assert property (ctl.flush |=> ctl.tx_byte == 8'h00) // R01
    else $error("flush did not empty transmit buffer");
  a_rx_flag_set: assert property (ev.rx_done |=> s_q.rx_flag && s_q.csr[BIT_RXBYTE]) // R03
    else $error("receive event lost");
  a_irq_gate: assert property (rx_irq |-> s_q.rx_en && s_q.rx_flag) // R04
    else $error("receive request without enable");
  a_tx_irq_gate: assert property (tx_irq |-> s_q.tx_en && s_q.tx_flag) // R04
    else $error("transmit request without enable");
  a_dma_pulse: assert property (ev.rx_done ##1 !ev.rx_done |-> rx_dma_trig ##1 !rx_dma_trig) // R05
    else $error("receive trigger not one pulse");
  a_mode_write: assert property (wr_q && idx_q == IDX_CTRL_STATUS |-> ctl.uart_mode == wb_q[BIT_MODE]) // R08
    else $error("mode bit not written");
  a_frame_sticky: assert property (ev.frame_fault |=> s_q.csr[BIT_FRAME]) // R11
    else $error("framing fault lost");
  a_parity_sticky: assert property (s_q.csr[BIT_PARITY] && !(wr_acc && idx == IDX_CTRL_STATUS)
                                    |=> s_q.csr[BIT_PARITY]) // R13
    else $error("parity fault dropped");
  a_busy_follow: assert property (ev.busy |=> s_q.csr[BIT_ACTIVE]) // R16
    else $error("busy not reported");
  a_flush_zero: assert property (setup && idx == IDX_ASYNC_CTRL |=> !prdata[BIT_FLUSH]) // R18
    else $error("flush bit reads one");
  a_slave_tx: assert property (!ctl.uart_mode && ctl.spi_slave && ev.slave_start |=> s_q.tx_flag) // R19
    else $error("slave start did not set transmit flag");
  a_set_wins: assert property (wr_acc && idx == IDX_IRQ_FLAGS && ev.rx_done |=> s_q.rx_flag) // R20
    else $error("coincident receive event lost");

  c_flush:   cover property (ctl.flush);
  c_rx_irq:  cover property (rx_irq);
  c_tx_slave: cover property (!ctl.uart_mode && ctl.spi_slave && ev.slave_start);
  c_unmapped: cover property (pslverr);
endmodule

// ==== sim/serial_engine_model.sv ====
// stand-in for the serial engine: turns bench requests into engine events
// assumes: same pclk as the block, bench requests are one-cycle pulses
`timescale 1ns/1ps
module serial_engine_model #(
  parameter int TX_CYC = 20
) (
  input  wire logic                   pclk,    // system clock
  input  wire logic                   presetn, // async reset, active low
  input  wire usart_pkg::engine_ctl_t ctl,     // controls from the block
  input  wire logic                   rx_req,  // deliver a byte
  input  wire logic [7:0]             rx_val,  // byte to deliver
  input  wire logic [1:0]             flt_req, // frame, parity fault
  output usart_pkg::engine_ev_t       ev       // events to the block
);
  import usart_pkg::*;
  int cnt;
  // byte bus toggles while not valid so a stale byte never passes for a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev  <= '0;
      cnt <= 0;
    end else begin
      ev.rx_done <= rx_req;
      ev.rx_byte <= rx_req ? rx_val : ~ev.rx_byte;
      {ev.frame_fault, ev.parity_fault} <= flt_req;
      ev.slave_start <= ctl.tx_load & ctl.spi_slave & ~ctl.uart_mode;
      ev.tx_done <= (cnt == 1) && !ctl.flush;
      ev.busy <= (ctl.tx_load || cnt > 1) && !ctl.flush;
      // flush kills a shift in progress, so no late done event
      if (ctl.flush) cnt <= 0;
      else if (ctl.tx_load) cnt <= TX_CYC;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule

// ==== sim/usart_status_flush_events_tb_top.sv ====
// self-checking bench for the status, flush and event block
// assumes: apb slave answers in its own time, engine model on the same clock
`timescale 1ns/1ps
module usart_status_flush_events_tb_top;
  import usart_pkg::*;
  localparam logic [11:0] A_CS = {2'h0, IDX_CTRL_STATUS, 2'h0};
  localparam logic [11:0] A_UC = {2'h0, IDX_ASYNC_CTRL, 2'h0};
  localparam logic [11:0] A_DB = {2'h0, IDX_DATA_BUF, 2'h0};
  localparam logic [11:0] A_IF = {2'h0, IDX_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] A_IE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, rx_irq, tx_irq, rx_dma_trig, tx_dma_trig, er;
  logic        rx_req = 1'b0;
  logic [7:0]  rx_val = 8'h00;
  logic [1:0]  flt_req = 2'h0;
  engine_ev_t  ev;
  engine_ctl_t ctl;
  int          num_errors = 0, n_compared = 0, n_rxt = 0, n_txt = 0, n_fl = 0, c;
  always #20 pclk = ~pclk;
  usart_status_flush_events dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .ctl(ctl), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .rx_dma_trig(rx_dma_trig), .tx_dma_trig(tx_dma_trig));
  serial_engine_model eng (.pclk(pclk), .presetn(presetn), .ctl(ctl), .rx_req(rx_req),
    .rx_val(rx_val), .flt_req(flt_req), .ev(ev));
  // pulse counters, so a trigger that stands two cycles shows up as two
  always @(posedge pclk) begin
    n_rxt += (rx_dma_trig === 1'b1);
    n_txt += (tx_dma_trig === 1'b1);
    n_fl  += (ctl.flush === 1'b1);
  end
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait count; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] regs [5] = '{A_CS, A_UC, 12'h314, A_DB, 12'h308};
    rd_chk(A_CS, 32'h00, "ctrl_status_reset");
    rd_chk(A_UC, 32'h02, "async_ctrl_reset");
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk("mapped_err", 32'h0, 32'(er));
    end
    apb(1'b0, 12'h7F0, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_rd", 32'h0, rd);
    // high address bits set: aliases the status index but must be refused
    apb(1'b1, 12'h618, 32'hFF);
    rd_chk(A_CS, 32'h00, "alias_write_ignored");
  endtask
  task automatic t_mode();
    apb(1'b1, A_CS, 32'hE0);
    // controls update at the access edge; look once they have settled
    @(negedge pclk);
    chk("mode_bits", 32'h7, 32'({ctl.uart_mode, ctl.receiver_on, ctl.spi_slave}));
    apb(1'b1, A_CS, 32'h40);
    rd_chk(A_CS, 32'h40, "mode_readback");
    chk("mode_bits_two", 32'h2, 32'({ctl.uart_mode, ctl.receiver_on, ctl.spi_slave}));
  endtask
  // plain configuration registers reach the engine and read back
  task automatic t_cfg();
    apb(1'b1, A_UC, 32'h15);
    apb(1'b1, 12'h314, 32'h25);
    apb(1'b1, 12'h308, 32'h83);
    @(negedge pclk);
    chk("cfg_to_engine", 32'h00152583, 32'({ctl.async_cfg, ctl.generic_cfg, ctl.rate_cfg}));
    rd_chk(A_UC, 32'h15, "async_readback");
    rd_chk(12'h314, 32'h25, "generic_readback");
    rd_chk(12'h308, 32'h83, "rate_readback");
  endtask
  // byte with parity fault, framing fault one cycle behind it
  task automatic t_rx();
    apb(1'b1, A_IE, 32'h3);
    apb(1'b1, A_CS, 32'hC0);
    c = n_rxt;
    @(posedge pclk);
    rx_req  <= 1'b1;
    rx_val  <= 8'hA5;
    flt_req <= 2'b01;
    @(posedge pclk);
    rx_req  <= 1'b0;
    flt_req <= 2'b10;
    @(posedge pclk);
    flt_req <= 2'b00;
    repeat (3) @(posedge pclk);
    chk("rx_dma_pulses", 32'h1, 32'(n_rxt - c));
    chk("rx_irq", 32'h1, 32'(rx_irq));
    rd_chk(A_CS, 32'hDC, "rx_status");
    rd_chk(A_DB, 32'hA5, "rx_byte");
    rd_chk(A_IF, 32'h1, "rx_flag");
    apb(1'b1, A_IE, 32'h2);
    repeat (2) @(posedge pclk);
    chk("rx_irq_masked", 32'h0, 32'(rx_irq));
    rd_chk(A_IE, 32'h2, "irq_enable_readback");
    apb(1'b1, A_CS, 32'hC0);
    rd_chk(A_CS, 32'hC0, "status_cleared");
    // receive event lands on the very edge of the clearing write
    fork
      apb(1'b1, A_IF, 32'h0);
      begin
        @(posedge pclk);
        rx_req <= 1'b1;
        @(posedge pclk);
        rx_req <= 1'b0;
      end
    join
    rd_chk(A_IF, 32'h1, "rx_flag_set_wins");
    apb(1'b1, A_IF, 32'h0);
  endtask
  task automatic t_tx();
    apb(1'b1, A_CS, 32'h80);
    c = n_txt;
    apb(1'b1, A_DB, 32'h3C);
    // load, engine busy and status bit each take one edge
    @(posedge pclk);
    rd_chk(A_CS, 32'h81, "tx_busy");
    chk("tx_byte", 32'h3C, 32'(ctl.tx_byte));
    for (int i = 0; i < 100 && n_txt == c; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("tx_dma_pulses", 32'h1, 32'(n_txt - c));
    chk("tx_irq", 32'h1, 32'(tx_irq));
    rd_chk(A_CS, 32'h82, "tx_status");
    rd_chk(A_IF, 32'h2, "tx_flag");
    apb(1'b1, A_IF, 32'h0);
  endtask
  // slave start raises the transmit flag early; flush then aborts the shift
  task automatic t_slave_flush();
    apb(1'b1, A_CS, 32'h20);
    apb(1'b1, A_DB, 32'h5A);
    @(posedge pclk);
    rd_chk(A_IF, 32'h2, "slave_tx_flag");
    rd_chk(A_CS, 32'h21, "slave_busy");
    c = n_fl;
    apb(1'b1, A_UC, 32'h82);
    rd_chk(A_UC, 32'h02, "flush_reads_zero");
    chk("flush_pulses", 32'h1, 32'(n_fl - c));
    // software waits a bit time before touching the port again
    repeat (8) @(posedge pclk);
    c = n_txt;
    rd_chk(A_CS, 32'h20, "flush_idle");
    rd_chk(A_DB, 32'h00, "flush_rx_empty");
    chk("flush_tx_empty", 32'h0, 32'(ctl.tx_byte));
    repeat (30) @(posedge pclk);
    chk("no_late_tx", 32'h0, 32'(n_txt - c));
    // in slave mode the trigger ignores the done event, so check the status bit too
    rd_chk(A_CS, 32'h20, "no_late_txbyte");
  endtask
  // phase select is never set, so the dma triggers stay usable throughout
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_cfg();
    t_rx();
    t_tx();
    t_slave_flush();
    summarize();
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule
